// ===== include/zfc_pkg.sv
// Package of command codes, reset values and timing constants for the Z filter command block
package zfc_pkg;
   // Command bytes with the read flag cleared; CMD_TX_READ has it set
   localparam logic [7:0] CMD_FIR_Z   = 8'h98;
   localparam logic [7:0] CMD_IIR_Z   = 8'h9A;
   localparam logic [7:0] CMD_DEBOUNCE = 8'hC8;
   localparam logic [7:0] CMD_TX_READ = 8'hCD;
   localparam logic [7:0] CMD_RW_MASK = 8'hFE;
   // Byte counts of the FIR, IIR and transmit read commands
   localparam logic [3:0] FIR_BYTES   = 4'hA;
   localparam logic [3:0] IIR_BYTES   = 4'h5;
   localparam logic [3:0] TX_BYTES    = 4'h2;
   // Reset values
   localparam logic [15:0] COEF4_RST  = 16'h0190;
   localparam logic [7:0]  COEF2_RST  = 8'h01;
   localparam logic [7:0]  CFG_RST    = 8'h20;
   // Config byte fields
   localparam int CFG_MUX_EN  = 7;
   localparam int CFG_MUX_POL = 6;
   localparam int CFG_DSH_HI  = 5;
   localparam int CFG_DSH_LO  = 2;
   localparam int CFG_CHOP_EN = 0;
   localparam logic [7:0] CFG_WR_MASK = 8'hFD;
   // Timing: 1 ms debounce unit at 200 MHz
   localparam int CLK_MHZ       = 200;
   localparam int MS_UNIT_US    = 1000;
   localparam int MS_CYCLES     = CLK_MHZ * MS_UNIT_US;
   // Chopper clock half period in cycles (256 kHz nominal)
   localparam int CHOP_KHZ      = 256;
   localparam int CHOP_HALF     = (CLK_MHZ * 1000) / (2 * CHOP_KHZ);
endpackage : zfc_pkg

// ===== src/zfc_cmd.sv
// Command interpreter for Z filter coefficients, debounce config and transmit sample read
// ****************************************************************
// ****************************************************************
`timescale 1ns/1ps
`default_nettype none
module zfc_cmd
(
   input  wire  logic        i_clk,
   input  wire  logic        i_rst_n,
   input  wire  logic        i_cmd_valid,      // First byte of a command
   input  wire  logic        i_wr_valid,       // Host data byte for a write
   input  wire  logic [7:0]  i_wr_data,
   input  wire  logic        i_rd_req,         // Host asks for next read byte
   input  wire  logic [7:0]  i_byte,           // Command byte; write data comes on i_wr_data
   output logic [7:0]        o_rd_data,
   output logic              o_rd_valid,
   output logic              o_busy,           // A command is in progress
   output logic [79:0]       o_fir_coef,
   output logic [39:0]       o_iir_coef,
   input  wire  logic        i_clock_mode_select,
   input  wire  logic        i_strobe_tick,    // Mux strobe timing from clock block
   output logic              o_mux_strobe_output,
   output logic              o_chopper_clock_out,
   input  wire  logic        i_hook_sense_input,
   output logic              o_hook_state,
   input  wire  logic [15:0] i_tx_sample,
   input  wire  logic        i_tx_new,         // New transmit sample pulse
   input  wire  logic        i_linear_mode,
   input  wire  logic        i_transmit_interrupt_arm,
   output logic              o_tx_irq,
   input  wire  logic signed [15:0] i_filt_in,
   input  wire  logic        i_sample_tick,    // 32 kHz sample enable
   output logic signed [15:0] o_filt_out
);
   // ****************************************************************
   // State
   // ****************************************************************
   typedef enum logic [2:0] {ZFC_IDLE, ZFC_FIR_WR, ZFC_IIR_WR, ZFC_CFG_WR, ZFC_RD} zfc_mode_e;

   typedef struct packed {
      zfc_mode_e    mode;
      logic [3:0]   cnt;
      logic [3:0]   total;
      logic [79:0]  rd_shadow;
      logic [79:0]  fir_stage;
      logic [39:0]  iir_stage;
      logic [79:0]  fir;
      logic [39:0]  iir;
      logic [7:0]   cfg;
      logic [7:0]   rd_data;
      logic         rd_valid;
      logic         hook_raw;
      logic         hook;
      logic [3:0]   db_ms;
      logic [17:0]  ms_cnt;
      logic         tx_irq;
      logic [9:0]   chop_cnt;
      logic         chop;
      logic         strobe;
      logic [3:0][15:0] fir_taps;        // Packed so the whole state stays one packed struct
      logic signed [15:0] iir_y;
      logic signed [15:0] out;
   } zfc_state_s;

   zfc_state_s s_q;
   zfc_state_s s_d;

   localparam logic [17:0] MS_LAST   = 18'(zfc_pkg::MS_CYCLES - 1);
   localparam logic [9:0]  CHOP_LAST = 10'(zfc_pkg::CHOP_HALF - 1);

   // Four-term nested CSD coefficient, Q2.12; two-term when two is set
   function automatic logic signed [15:0] zfc_csd(input logic [15:0] c, input logic two);
      logic signed [15:0] acc;
      logic [4:0]         sh;
      acc = 16'sh0000;
      sh  = 5'h00;
      for (int k = 0; k < 4; k++)
      begin
         // Nibble k: positions 1 (low nibble of second byte) outward
         sh = sh + {2'b00, c[4*k +: 3]};
         if (!(two && k > 1))
         begin
            if (^c[3:0] ^ ^c[3:0] ^ (c[3] ^ (k > 0 ? c[7] : 1'b0)) ^ 1'b0 ^
                (k > 1 ? c[11] : 1'b0) ^ (k > 2 ? c[15] : 1'b0))
               acc = acc - (16'sh1000 >>> sh);
            else
               acc = acc + (16'sh1000 >>> sh);
         end
      end
      return acc;
   endfunction

   // Coefficient halves packed as {byte1, byte2}: low byte holds positions 2,1
   function automatic logic [15:0] zfc_pair(input logic [79:0] v, input int i);
      return {v[16*i +: 8], v[16*i+8 +: 8]};
   endfunction

   // Q2.12 multiply back to Q sample width
   function automatic logic signed [15:0] zfc_mul(input logic signed [15:0] a,
                                                  input logic signed [15:0] b);
      logic signed [31:0] p;
      p = a * b;
      return p[27:12];
   endfunction

   logic signed [15:0] z_coef [0:7];
   logic signed [15:0] iir_in;
   always_comb
   begin
      for (int i = 0; i < 5; i++)
         z_coef[i] = zfc_csd(zfc_pair(s_q.fir, i), 1'b0);
      z_coef[5] = zfc_csd({s_q.iir[7:0], s_q.iir[15:8]}, 1'b0);
      z_coef[6] = zfc_csd({8'h00, s_q.iir[23:16]}, 1'b1);
      z_coef[7] = zfc_csd({s_q.iir[31:24], s_q.iir[39:32]}, 1'b0);
      // Input raised by 1/z6 is folded into z5; output scaled by z6
      iir_in = zfc_mul(i_filt_in, z_coef[5]);
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb
   begin
      logic signed [15:0] fir_sum;
      logic               cmd_fir;
      logic               cmd_iir;
      fir_sum  = 16'sh0000;
      s_d      = s_q;
      s_d.rd_valid = 1'b0;
      cmd_fir  = (i_byte & zfc_pkg::CMD_RW_MASK) == zfc_pkg::CMD_FIR_Z;
      cmd_iir  = (i_byte & zfc_pkg::CMD_RW_MASK) == zfc_pkg::CMD_IIR_Z;
      // Command decode, only when idle
      if (i_cmd_valid && s_q.mode == ZFC_IDLE)
      begin
         s_d.cnt = 4'h0;
         if (cmd_fir || cmd_iir)
         begin
            s_d.total = cmd_fir ? zfc_pkg::FIR_BYTES : zfc_pkg::IIR_BYTES;
            s_d.fir_stage = s_q.fir;
            s_d.iir_stage = s_q.iir;
            s_d.rd_shadow = cmd_fir ? s_q.fir : {40'h0, s_q.iir};
            if (i_byte[0])
               s_d.mode = ZFC_RD;
            else
               s_d.mode = cmd_fir ? ZFC_FIR_WR : ZFC_IIR_WR;
         end
         else if ((i_byte & zfc_pkg::CMD_RW_MASK) == zfc_pkg::CMD_DEBOUNCE)
         begin
            s_d.total = 4'h1;
            s_d.rd_shadow = {72'h0, s_q.cfg};
            s_d.mode = i_byte[0] ? ZFC_RD : ZFC_CFG_WR;
         end
         else if (i_byte == zfc_pkg::CMD_TX_READ)
         begin
            s_d.total = zfc_pkg::TX_BYTES;
            // Sample byte first, reserved byte reads as zero
            s_d.rd_shadow = {64'h0, 8'h00,
                             i_linear_mode ? i_tx_sample[15:8] : i_tx_sample[7:0]};
            s_d.mode = ZFC_RD;
            s_d.tx_irq = 1'b0;
         end
      end
      else
      begin
         case (s_q.mode)
            ZFC_FIR_WR, ZFC_IIR_WR, ZFC_CFG_WR:
               if (i_wr_valid)
               begin
                  if (s_q.mode == ZFC_FIR_WR)
                     s_d.fir_stage[8*s_q.cnt +: 8] = i_wr_data;
                  else if (s_q.mode == ZFC_IIR_WR)
                     s_d.iir_stage[8*s_q.cnt[2:0] +: 8] = i_wr_data;
                  else
                     s_d.cfg = i_wr_data & zfc_pkg::CFG_WR_MASK;
                  s_d.cnt = s_q.cnt + 4'h1;
                  if (s_q.cnt + 4'h1 == s_q.total)
                  begin
                     // Commit whole set at once so the filter never sees half
                     if (s_q.mode == ZFC_FIR_WR)
                        s_d.fir = s_d.fir_stage;
                     if (s_q.mode == ZFC_IIR_WR)
                        s_d.iir = s_d.iir_stage;
                     s_d.mode = ZFC_IDLE;
                  end
               end
            ZFC_RD:
               if (i_rd_req)
               begin
                  s_d.rd_data  = s_q.rd_shadow[8*s_q.cnt +: 8];
                  s_d.rd_valid = 1'b1;
                  s_d.cnt      = s_q.cnt + 4'h1;
                  if (s_q.cnt + 4'h1 == s_q.total)
                     s_d.mode = ZFC_IDLE;
               end
            default:
               s_d.mode = ZFC_IDLE;
         endcase
      end
      // New sample sets the flag while armed; set wins over the read clear
      if (i_tx_new && i_transmit_interrupt_arm)
         s_d.tx_irq = 1'b1;
      if (!i_transmit_interrupt_arm)
         s_d.tx_irq = 1'b0;
      // Hook debounce: count whole ms while raw differs from settled value
      s_d.hook_raw = i_hook_sense_input;
      if (s_q.hook_raw != s_q.hook)
      begin
         if (s_q.db_ms >= s_q.cfg[zfc_pkg::CFG_DSH_HI:zfc_pkg::CFG_DSH_LO])
         begin
            s_d.hook  = s_q.hook_raw;
            s_d.db_ms = 4'h0;
            s_d.ms_cnt = 18'h00000;
         end
         else if (s_q.ms_cnt == MS_LAST)
         begin
            s_d.ms_cnt = 18'h00000;
            s_d.db_ms  = s_q.db_ms + 4'h1;
         end
         else
            s_d.ms_cnt = s_q.ms_cnt + 18'h00001;
      end
      else
      begin
         s_d.db_ms  = 4'h0;
         s_d.ms_cnt = 18'h00000;
      end
      // Chopper divider runs only while enabled
      if (s_q.cfg[zfc_pkg::CFG_CHOP_EN])
      begin
         s_d.chop_cnt = (s_q.chop_cnt == CHOP_LAST) ? 10'h000 : s_q.chop_cnt + 10'h001;
         if (s_q.chop_cnt == CHOP_LAST)
            s_d.chop = ~s_q.chop;
      end
      else
      begin
         s_d.chop_cnt = 10'h000;
         s_d.chop     = 1'b0;
      end
      // Strobe idle level follows polarity; active level is the inverse
      s_d.strobe = (i_clock_mode_select
                    && s_q.cfg[zfc_pkg::CFG_MUX_EN]
                    && i_strobe_tick)
                   ^ s_q.cfg[zfc_pkg::CFG_MUX_POL];
      // Z filter at the sample enable
      if (i_sample_tick)
      begin
         fir_sum = zfc_mul(i_filt_in, z_coef[0]);
         for (int t = 0; t < 4; t++)
            fir_sum = fir_sum + zfc_mul(s_q.fir_taps[t], z_coef[t+1]);
         s_d.fir_taps[0] = i_filt_in;
         for (int t = 1; t < 4; t++)
            s_d.fir_taps[t] = s_q.fir_taps[t-1];
         s_d.iir_y = iir_in + zfc_mul(s_q.iir_y, z_coef[7]);
         s_d.out   = fir_sum + zfc_mul(zfc_mul(s_q.iir_y, z_coef[7]), z_coef[6]);
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         s_q <= '0;
         s_q.mode <= ZFC_IDLE;
         s_q.fir  <= {5{zfc_pkg::COEF4_RST[7:0], zfc_pkg::COEF4_RST[15:8]}};
         s_q.iir  <= {zfc_pkg::COEF4_RST[7:0], zfc_pkg::COEF4_RST[15:8],
                      zfc_pkg::COEF2_RST,
                      zfc_pkg::COEF4_RST[7:0], zfc_pkg::COEF4_RST[15:8]};
         s_q.cfg  <= zfc_pkg::CFG_RST;
      end
      else
         s_q <= s_d;
   end

   // Outputs
   assign o_rd_data  = s_q.rd_data;
   assign o_rd_valid = s_q.rd_valid;
   assign o_busy     = s_q.mode != ZFC_IDLE;
   assign o_fir_coef = s_q.fir;
   assign o_iir_coef = s_q.iir;
   assign o_mux_strobe_output = s_q.strobe;
   assign o_chopper_clock_out = s_q.chop;
   assign o_hook_state = s_q.hook;
   assign o_tx_irq   = s_q.tx_irq;
   assign o_filt_out = s_q.out;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   sequence fir_wr_last;
      s_q.mode == ZFC_FIR_WR && i_wr_valid && s_q.cnt == 4'h9;
   endsequence
   a_fir_commit_whole: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      fir_wr_last |=> (s_q.fir == $past(s_d.fir_stage)) && s_q.mode == ZFC_IDLE)
      else $error("FIR set not committed on tenth byte");
   a_fir_keeps_iir: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      s_q.mode == ZFC_FIR_WR |=> $stable(s_q.iir))
      else $error("IIR changed during FIR write");
   a_iir_keeps_fir: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      s_q.mode == ZFC_IIR_WR |=> $stable(s_q.fir))
      else $error("FIR changed during IIR write");
   a_no_partial_fir: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (s_q.mode == ZFC_FIR_WR && s_q.cnt < 4'h9) |=> $stable(s_q.fir))
      else $error("FIR changed before last byte");
   a_strobe_clock_mode_select: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !i_clock_mode_select |=> s_q.strobe == $past(s_q.cfg[zfc_pkg::CFG_MUX_POL]))
      else $error("Strobe pulsed without clock mode");
   a_chop_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !s_q.cfg[zfc_pkg::CFG_CHOP_EN] [*2] |-> !o_chopper_clock_out)
      else $error("Chopper runs while disabled");
   a_tx_read_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_cmd_valid && s_q.mode == ZFC_IDLE && i_byte == zfc_pkg::CMD_TX_READ && !i_tx_new)
      |=> !o_tx_irq ##1 (s_q.mode == ZFC_RD))
      else $error("Transmit flag not cleared by read");
   a_tx_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_tx_new && i_transmit_interrupt_arm) |=> o_tx_irq)
      else $error("Transmit flag not set");
   a_hook_stable: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $changed(s_q.hook) |-> $past(s_q.hook_raw) == s_q.hook)
      else $error("Hook changed to wrong value");
endmodule // zfc_cmd
`default_nettype wire

// ===== tb/zfc_host.sv
// Host model issuing command, write and read bytes to the Z filter command block
`timescale 1ns/1ps
`default_nettype none
module zfc_host
(
   input  wire logic       i_clk,
   input  wire logic       i_rd_valid,
   input  wire logic [7:0] i_rd_data,
   output var  logic       o_cmd_valid,
   output var  logic       o_wr_valid,
   output var  logic [7:0] o_wr_data,
   output var  logic       o_rd_req,
   output var  logic [7:0] o_byte
);
   // Idle lines start known so the block never sees an unknown byte
   initial
   begin
      {o_cmd_valid, o_wr_valid, o_rd_req} = 3'h0;
      o_wr_data = 8'h00;
      o_byte    = 8'h00;
   end
   // Released lines show the inverse so stale data is never taken as fresh
   task automatic send_cmd(input logic [7:0] c);
      @(posedge i_clk);
      #1;
      o_cmd_valid = 1'b1;
      o_byte      = c;
      @(posedge i_clk);
      #1;
      o_cmd_valid = 1'b0;
      o_byte      = ~c;
   endtask
   // One data byte, sent unchanged; reserved config bits are not forced to zero
   task automatic send_byte(input logic [7:0] d);
      @(posedge i_clk);
      #1;
      o_wr_valid = 1'b1;
      o_wr_data  = d;
      @(posedge i_clk);
      #1;
      o_wr_valid = 1'b0;
      o_wr_data  = ~d;
   endtask
   // One read byte, answer awaited under a small bound
   task automatic get_byte(output logic [7:0] d);
      int n;
      @(posedge i_clk);
      #1;
      o_rd_req = 1'b1;
      @(posedge i_clk);
      #1;
      o_rd_req = 1'b0;
      n = 0;
      while (i_rd_valid !== 1'b1 && n < 4)
      begin
         @(posedge i_clk);
         #1;
         n++;
      end
      d = (i_rd_valid === 1'b1) ? i_rd_data : 8'hXX;
   endtask
endmodule // zfc_host
`default_nettype wire

// ===== tb/zfilter_debounce_txread_cmds_tb_top.sv
// Testbench for the Z filter, debounce config and transmit read command block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module zfilter_debounce_txread_cmds_tb_top;
   logic        i_clk = 1'b0, i_rst_n = 1'b0, cmd_v, wr_v, rd_req, rd_v, clock_mode_select = 1'b0;
   logic        tick = 1'b0, hook = 1'b0, tx_new = 1'b0, lin = 1'b1, arm = 1'b0, stick = 1'b0;
   logic [7:0]  wr_d, byte_i, rd_d;
   logic [15:0] tx_s = 16'hA55A;
   logic [15:0] filt_in = 16'h1000;
   logic [79:0] fir, exp_fir;
   logic [39:0] iir, exp_iir;
   logic        busy, strobe, chop, hook_st, irq;
   logic [15:0] filt_out;
   logic [7:0]  rb [10];
   int          n_errors = 0, cmp_count = 0, cyc = 0, n;
   always #2.5 i_clk = ~i_clk;
   zfc_host u_host (.i_clk(i_clk), .i_rd_valid(rd_v), .i_rd_data(rd_d), .o_cmd_valid(cmd_v),
      .o_wr_valid(wr_v), .o_wr_data(wr_d), .o_rd_req(rd_req), .o_byte(byte_i));
   zfc_cmd uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd_valid(cmd_v), .i_wr_valid(wr_v),
      .i_wr_data(wr_d), .i_rd_req(rd_req), .i_byte(byte_i), .o_rd_data(rd_d), .o_rd_valid(rd_v),
      .o_busy(busy), .o_fir_coef(fir), .o_iir_coef(iir), .i_clock_mode_select(clock_mode_select),
      .i_strobe_tick(tick), .o_mux_strobe_output(strobe), .o_chopper_clock_out(chop),
      .i_hook_sense_input(hook), .o_hook_state(hook_st), .i_tx_sample(tx_s), .i_tx_new(tx_new),
      .i_linear_mode(lin), .i_transmit_interrupt_arm(arm), .o_tx_irq(irq),
      .i_filt_in(filt_in), .i_sample_tick(stick), .o_filt_out(filt_out));
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic end_of_test;
      $display("Counts: %0d compares, %0d mismatches", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Reads n bytes of one command into rb
   task automatic rd_cmd(input logic [7:0] c, input int nb);
      u_host.send_cmd(c);
      for (int k = 0; k < nb; k++)
         u_host.get_byte(rb[k]);
   endtask
   // Waits a bounded number of cycles for a level on a design output
   task automatic wait_for(ref logic s, input logic v, input int lim);
      n = 0;
      while (s !== v && n < lim)
      begin
         @(posedge i_clk);
         #1;
         n++;
      end
   endtask
   // Hang guard, far above the few hundred cycles the tests need
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         end_of_test();
      end
   end
   // ****************************************************************
   // Test sequence
   // ****************************************************************
   initial
   begin
      repeat (5) @(posedge i_clk);
      #1;
      i_rst_n = 1'b1;
      `CHK(fir, {5{16'h9001}})
      `CHK(iir, 40'h9001019001)
      rd_cmd(8'hC9, 1);
      `CHK(rb[0], 8'h20)
      `CHK(chop, 1'b0)
      // Any input must give zero output while every coefficient is at reset
      filt_in = 16'h0800;
      repeat (6)
      begin
         @(posedge i_clk);
         #1;
         stick = ~stick;
      end
      `CHK(filt_out, 16'h0000)
      $display("test reset values done");
      // FIR set, last byte held back to see no partial commit
      u_host.send_cmd(8'h98);
      for (int k = 0; k < 10; k++)
      begin
         exp_fir[8*k +: 8] = 8'h11 * (k + 1);
         if (k == 9)
            `CHK(fir, {5{16'h9001}})
         u_host.send_byte(exp_fir[8*k +: 8]);
      end
      @(posedge i_clk);
      #1;
      `CHK(fir, exp_fir)
      `CHK(iir, 40'h9001019001)
      rd_cmd(8'h99, 10);
      for (int k = 0; k < 10; k++)
         `CHK(rb[k], exp_fir[8*k +: 8])
      $display("test fir coefficients done");
      // IIR set: z5, z6 two-term byte, z7
      exp_iir = 40'hC3_5A_96_E1_2F;
      u_host.send_cmd(8'h9A);
      for (int k = 0; k < 5; k++)
         u_host.send_byte(exp_iir[8*k +: 8]);
      @(posedge i_clk);
      #1;
      `CHK(iir, exp_iir)
      `CHK(fir, exp_fir)
      rd_cmd(8'h9B, 5);
      for (int k = 0; k < 5; k++)
         `CHK(rb[k], exp_iir[8*k +: 8])
      $display("test iir coefficients done");
      // Config: mux on, low-going, zero debounce, chopper on
      u_host.send_cmd(8'hC8);
      u_host.send_byte(8'hC1);
      rd_cmd(8'hC9, 1);
      `CHK(rb[0], 8'hC1)
      tick = 1'b1;
      repeat (3) @(posedge i_clk);
      #1;
      `CHK(strobe, 1'b1)
      clock_mode_select = 1'b1;
      wait_for(strobe, 1'b0, 4);
      `CHK(strobe, 1'b0)
      wait_for(chop, 1'b1, 2 * zfc_pkg::CHOP_HALF + 4);
      `CHK(chop, 1'b1)
      hook = 1'b1;
      wait_for(hook_st, 1'b1, 1000);
      `CHK(hook_st, 1'b1)
      u_host.send_cmd(8'hC8);
      u_host.send_byte(8'h20);
      repeat (3) @(posedge i_clk);
      #1;
      `CHK(strobe, 1'b0)
      `CHK(chop, 1'b0)
      $display("test debounce config done");
      // Transmit sample read with interrupt arming
      arm = 1'b1;
      tx_new = 1'b1;
      @(posedge i_clk);
      #1;
      tx_new = 1'b0;
      @(posedge i_clk);
      #1;
      `CHK(irq, 1'b1)
      rd_cmd(8'hCD, 2);
      `CHK(rb[0], 8'hA5)
      `CHK(irq, 1'b0)
      `CHK(busy, 1'b0)
      // Companded mode hands back the code byte instead of the upper linear byte
      lin  = 1'b0;
      tx_s = 16'h3CC3;
      rd_cmd(8'hCD, 2);
      `CHK(rb[0], 8'hC3)
      $display("test transmit read done");
      // Reset in mid-run brings every store back to its power-up value
      i_rst_n = 1'b0;
      repeat (2) @(posedge i_clk);
      #1;
      i_rst_n = 1'b1;
      `CHK(fir, {5{16'h9001}})
      `CHK(iir, 40'h9001019001)
      rd_cmd(8'hC9, 1);
      `CHK(rb[0], 8'h20)
      $display("test mid-run reset done");
      end_of_test();
   end
endmodule // zfilter_debounce_txread_cmds_tb_top
`default_nettype wire
